/* File: hbb_pkg.sv */
// constants and helpers for the host bus register bank
package hbb_pkg;
    // byte offsets inside the decoded window
    localparam logic [3:0] OFF_BASE = 4'h0;
    localparam logic [3:0] OFF_MAC_LOW = 4'h0;
    localparam logic [3:0] OFF_MAC_MID = 4'h2;
    localparam logic [3:0] OFF_MAC_HIGH = 4'h4;
    localparam logic [3:0] OFF_WATERMARK = 4'h4;
    localparam logic [3:0] OFF_BUS_ERR = 4'h6;
    localparam logic [3:0] OFF_BURST = 4'h8;
    localparam logic [3:0] OFF_BANK_SEL_DW = 4'hC;
    localparam logic [3:0] OFF_BANK_SEL = 4'hE;
    // banks
    localparam logic [5:0] BANK_BASE = 6'h00;
    localparam logic [5:0] BANK_MAC = 6'h02;
    localparam int BANK_W = 6;
    // reset values and writable masks
    localparam logic [15:0] BASE_RESET = 16'h0300;
    localparam logic [15:0] BASE_MASK = 16'hFFE0;
    localparam logic [15:0] WM_MASK = 16'h1000;
    localparam logic [15:0] BURST_MASK = 16'h7000;
    localparam logic [15:0] BANK_MASK = 16'h003F;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // field positions
    localparam int WM_BIT = 12;
    localparam int ERR_BAD_LANE_BIT = 15;
    localparam int ERR_VALUE_LSB = 11;
    localparam int ERR_MIXED_BIT = 10;
    localparam int BURST_LSB = 12;
    localparam int ADDR_CMP_LSB = 5;
    localparam int ADDR_WIN_BIT = 4;
    // watermark sizes in bytes
    localparam logic [11:0] WM_3K_BYTES = 12'hC00;
    localparam logic [11:0] WM_2K_BYTES = 12'h800;
    // burst length codes and beat counts
    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_4 = 3'h3;
    localparam logic [2:0] BURST_8 = 3'h5;
    localparam logic [2:0] BURST_16 = 3'h7;
    localparam logic [4:0] BEATS_1 = 5'h01;
    localparam logic [4:0] BEATS_4 = 5'h04;
    localparam logic [4:0] BEATS_8 = 5'h08;
    localparam logic [4:0] BEATS_16 = 5'h10;
    // eeprom word map and strap settling
    localparam logic [5:0] EE_WORD_BASE = 6'h00;
    localparam logic [1:0] EE_LAST_IDX = 2'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    function automatic logic hbb_be_legal(input logic [3:0] be);
        case (be)
            4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: hbb_be_legal = 1'b1;
            default: hbb_be_legal = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] hbb_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] be);
        hbb_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction
endpackage

/* File: hbb_host_bus_bank.sv */
// host bus register front end: base decode, banks, bus errors, eeprom load
// Summary of operation
// - write-one-to-clear bits clear on a one, stay on a zero.
// - six-bit bank selector picks one of 64 banks, resets to zero.
// - bank selector answers at the same offset in every bank.
// - selector reachable as 32-bit at 0xC, or 16/8-bit at 0xE.
// - 32-bit write at 0xC leaves 0xC and 0xD untouched.
// - with eeprom pin high, base address loads from eeprom word 0.
// - host may rewrite base; the eeprom is never written.
// - with eeprom pin low, base address resets to 0x0300.
// - device selected when address bits 15:8 and 7:5 match base and address bit 4 is zero.
// - watermark bit 12 picks 3 KBytes (0) or 2 KBytes (1).
// - illegal byte enables set error bit 15; host writes one to clear.
// - illegal byte enables captured into bits 14 to 11.
// - simultaneous sync and async transfers set bit 10; one clears.
// - burst field 14-12: single, fixed 4, 8 or 16; resets to zero.
// - bank 1 is reserved except the bank selector.
// - after reset with eeprom pin high, MAC words load from eeprom words 1 onward.
// - eeprom words 1, 2, 3 feed low, middle, high MAC words.
// - MAC register writes never modify the eeprom.
// - middle and high MAC words sit in bank 2 at 0x02 and 0x04.
`timescale 1ns/10ps
module hbb_host_bus_bank (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic eeprom_present_pin,
    input wire logic host_strobe,
    input wire logic host_write,
    input wire logic [15:0] host_addr,
    input wire logic [3:0] host_be,
    input wire logic [31:0] host_wdata,
    input wire logic sync_xfer_active,
    input wire logic async_xfer_active,
    output logic host_ack,
    output logic [31:0] host_rdata,
    output logic ee_rd_req,
    output logic [5:0] ee_rd_addr,
    input wire logic ee_rd_ack,
    input wire logic [15:0] ee_rd_data,
    output logic [5:0] bank_choice_field,
    output logic [11:0] rx_hiwm_bytes,
    output logic [4:0] burst_beats,
    output logic load_done
);
    typedef enum logic [2:0] {
        LD_SETTLE = 3'b001,
        LD_FETCH = 3'b010,
        LD_DONE = 3'b100
    } hbb_load_t;

    logic rst_s1;
    logic rst_n;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;

    // reset release through two stages
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // strap pin comes from outside, three stages
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= eeprom_present_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // eeprom loader
    hbb_load_t state;
    hbb_load_t next_state;
    logic [1:0] settle_cnt;
    logic [1:0] next_settle_cnt;
    logic [1:0] word_idx;
    logic [1:0] next_word_idx;
    logic next_ee_rd_req;
    logic [5:0] next_ee_rd_addr;
    logic next_load_done;

    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_word_idx = word_idx;
        next_ee_rd_req = ee_rd_req;
        next_ee_rd_addr = ee_rd_addr;
        next_load_done = load_done;
        case (state)
            LD_SETTLE: begin
                // strap taken only once the last two stages agree
                if (settle_cnt == hbb_pkg::STRAP_SETTLE && pin_s2 == pin_s3) begin
                    if (pin_s3) begin
                        next_state = LD_FETCH;
                        next_ee_rd_req = 1'b1;
                        next_ee_rd_addr = hbb_pkg::EE_WORD_BASE;
                        next_word_idx = 2'h0;
                    end else begin
                        next_state = LD_DONE;
                        next_load_done = 1'b1;
                    end
                end else if (settle_cnt != hbb_pkg::STRAP_SETTLE) begin
                    next_settle_cnt = settle_cnt + 2'h1;
                end
            end
            LD_FETCH: begin
                if (ee_rd_ack) begin
                    if (word_idx == hbb_pkg::EE_LAST_IDX) begin
                        next_state = LD_DONE;
                        next_ee_rd_req = 1'b0;
                        next_load_done = 1'b1;
                    end else begin
                        next_word_idx = word_idx + 2'h1;
                        next_ee_rd_addr = ee_rd_addr + 6'h01;
                    end
                end
            end
            LD_DONE: begin
                next_ee_rd_req = 1'b0;
            end
            default: begin
                next_state = LD_SETTLE;
                next_ee_rd_req = 1'b0;
                next_load_done = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= LD_SETTLE;
            settle_cnt <= 2'h0;
            word_idx <= 2'h0;
            ee_rd_req <= 1'b0;
            ee_rd_addr <= 6'h00;
            load_done <= 1'b0;
        end else begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            word_idx <= next_word_idx;
            ee_rd_req <= next_ee_rd_req;
            ee_rd_addr <= next_ee_rd_addr;
            load_done <= next_load_done;
        end
    end

    // register file and bus answer
    logic [15:0] base_address_decode;
    logic [15:0] host_mac_address_low;
    logic [15:0] host_mac_address_middle;
    logic [15:0] host_mac_address_high;
    logic [15:0] rx_watermark_config;
    logic [15:0] bus_error_flags;
    logic [15:0] burst_length_setup;
    logic [15:0] register_bank_selector;
    logic [15:0] next_base;
    logic [15:0] next_mac_low;
    logic [15:0] next_mac_mid;
    logic [15:0] next_mac_high;
    logic [15:0] next_wm;
    logic [15:0] next_err;
    logic [15:0] next_burst;
    logic [15:0] next_bank;
    logic next_host_ack;
    logic [31:0] next_host_rdata;
    logic [11:0] next_rx_hiwm_bytes;
    logic [4:0] next_burst_beats;
    logic hit;
    logic be_ok;
    logic wr;
    logic bank0;
    logic bank2;
    logic [1:0] word;
    logic [31:0] rd_word;
    logic [31:0] lane_mask;
    logic clr_bad;
    logic clr_mixed;
    logic ev_bad;
    logic ev_mixed;

    always_comb begin
        // the eeprom is only ever read, so host writes never reach it
        hit = host_strobe && load_done &&
              host_addr[15:hbb_pkg::ADDR_CMP_LSB] == base_address_decode[15:hbb_pkg::ADDR_CMP_LSB] &&
              !host_addr[hbb_pkg::ADDR_WIN_BIT];
        be_ok = hbb_pkg::hbb_be_legal(host_be);
        wr = hit && host_write && be_ok;
        word = host_addr[3:2];
        bank0 = register_bank_selector[hbb_pkg::BANK_W-1:0] == hbb_pkg::BANK_BASE;
        bank2 = register_bank_selector[hbb_pkg::BANK_W-1:0] == hbb_pkg::BANK_MAC;
        lane_mask = {{8{host_be[3]}}, {8{host_be[2]}}, {8{host_be[1]}}, {8{host_be[0]}}};
        next_base = base_address_decode;
        next_mac_low = host_mac_address_low;
        next_mac_mid = host_mac_address_middle;
        next_mac_high = host_mac_address_high;
        next_wm = rx_watermark_config;
        next_burst = burst_length_setup;
        next_bank = register_bank_selector;
        // eeprom words land in order: base, then MAC low, middle, high
        if (state == LD_FETCH && ee_rd_ack) begin
            case (word_idx)
                2'h0: next_base = ee_rd_data & hbb_pkg::BASE_MASK;
                2'h1: next_mac_low = ee_rd_data;
                2'h2: next_mac_mid = ee_rd_data;
                default: next_mac_high = ee_rd_data;
            endcase
        end
        if (wr) begin
            // upper half only; lanes 1:0 at 0xC/0xD are dropped
            if (word == hbb_pkg::OFF_BANK_SEL_DW[3:2]) begin
                next_bank = hbb_pkg::hbb_merge(register_bank_selector, host_wdata[31:16], host_be[3:2])
                            & hbb_pkg::BANK_MASK;
            end
            if (bank0) begin
                if (word == hbb_pkg::OFF_BASE[3:2]) begin
                    next_base = hbb_pkg::hbb_merge(base_address_decode, host_wdata[15:0], host_be[1:0])
                                & hbb_pkg::BASE_MASK;
                end
                if (word == hbb_pkg::OFF_WATERMARK[3:2]) begin
                    next_wm = hbb_pkg::hbb_merge(rx_watermark_config, host_wdata[15:0], host_be[1:0])
                              & hbb_pkg::WM_MASK;
                end
                if (word == hbb_pkg::OFF_BURST[3:2]) begin
                    next_burst = hbb_pkg::hbb_merge(burst_length_setup, host_wdata[15:0], host_be[1:0])
                                 & hbb_pkg::BURST_MASK;
                end
            end
            if (bank2) begin
                if (word == hbb_pkg::OFF_MAC_LOW[3:2]) begin
                    next_mac_low = hbb_pkg::hbb_merge(host_mac_address_low, host_wdata[15:0], host_be[1:0]);
                    next_mac_mid = hbb_pkg::hbb_merge(host_mac_address_middle, host_wdata[31:16],
                                                      host_be[3:2]);
                end
                if (word == hbb_pkg::OFF_MAC_HIGH[3:2]) begin
                    next_mac_high = hbb_pkg::hbb_merge(host_mac_address_high, host_wdata[15:0],
                                                       host_be[1:0]);
                end
            end
        end
        // error flags: set beats a clear in the same cycle
        ev_bad = hit && !be_ok;
        ev_mixed = sync_xfer_active && async_xfer_active;
        clr_bad = wr && bank0 && word == hbb_pkg::OFF_BUS_ERR[3:2] && host_be[3] &&
                  host_wdata[16 + hbb_pkg::ERR_BAD_LANE_BIT];
        clr_mixed = wr && bank0 && word == hbb_pkg::OFF_BUS_ERR[3:2] && host_be[3] &&
                    host_wdata[16 + hbb_pkg::ERR_MIXED_BIT];
        next_err = bus_error_flags;
        next_err[hbb_pkg::ERR_BAD_LANE_BIT] = ev_bad ||
            (bus_error_flags[hbb_pkg::ERR_BAD_LANE_BIT] && !clr_bad);
        next_err[hbb_pkg::ERR_MIXED_BIT] = ev_mixed ||
            (bus_error_flags[hbb_pkg::ERR_MIXED_BIT] && !clr_mixed);
        if (ev_bad) begin
            next_err[hbb_pkg::ERR_VALUE_LSB +: 4] = host_be;
        end
        // read mux; unmapped and reserved bits give zero
        rd_word = 32'h0000_0000;
        case (word)
            2'h0: begin
                if (bank0) begin
                    rd_word = {hbb_pkg::ZERO16, base_address_decode};
                end else if (bank2) begin
                    rd_word = {host_mac_address_middle, host_mac_address_low};
                end
            end
            2'h1: begin
                if (bank0) begin
                    rd_word = {bus_error_flags, rx_watermark_config};
                end else if (bank2) begin
                    rd_word = {hbb_pkg::ZERO16, host_mac_address_high};
                end
            end
            2'h2: begin
                if (bank0) begin
                    rd_word = {hbb_pkg::ZERO16, burst_length_setup};
                end
            end
            default: rd_word = {register_bank_selector, hbb_pkg::ZERO16};
        endcase
        next_host_ack = hit;
        next_host_rdata = (hit && !host_write && be_ok) ? (rd_word & lane_mask) : 32'h0000_0000;
        next_rx_hiwm_bytes = next_wm[hbb_pkg::WM_BIT] ? hbb_pkg::WM_2K_BYTES : hbb_pkg::WM_3K_BYTES;
        // undocumented codes fall back to single transfers
        case (next_burst[hbb_pkg::BURST_LSB +: 3])
            hbb_pkg::BURST_4: next_burst_beats = hbb_pkg::BEATS_4;
            hbb_pkg::BURST_8: next_burst_beats = hbb_pkg::BEATS_8;
            hbb_pkg::BURST_16: next_burst_beats = hbb_pkg::BEATS_16;
            hbb_pkg::BURST_SINGLE: next_burst_beats = hbb_pkg::BEATS_1;
            default: next_burst_beats = hbb_pkg::BEATS_1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            base_address_decode <= hbb_pkg::BASE_RESET;
            host_mac_address_low <= hbb_pkg::ZERO16;
            host_mac_address_middle <= hbb_pkg::ZERO16;
            host_mac_address_high <= hbb_pkg::ZERO16;
            rx_watermark_config <= hbb_pkg::ZERO16;
            bus_error_flags <= hbb_pkg::ZERO16;
            burst_length_setup <= hbb_pkg::ZERO16;
            register_bank_selector <= hbb_pkg::ZERO16;
            host_ack <= 1'b0;
            host_rdata <= 32'h0000_0000;
            rx_hiwm_bytes <= hbb_pkg::WM_3K_BYTES;
            burst_beats <= hbb_pkg::BEATS_1;
        end else begin
            base_address_decode <= next_base;
            host_mac_address_low <= next_mac_low;
            host_mac_address_middle <= next_mac_mid;
            host_mac_address_high <= next_mac_high;
            rx_watermark_config <= next_wm;
            bus_error_flags <= next_err;
            burst_length_setup <= next_burst;
            register_bank_selector <= next_bank;
            host_ack <= next_host_ack;
            host_rdata <= next_host_rdata;
            rx_hiwm_bytes <= next_rx_hiwm_bytes;
            burst_beats <= next_burst_beats;
        end
    end

    assign bank_choice_field = register_bank_selector[hbb_pkg::BANK_W-1:0];
endmodule

/* File: hbb_bank_props.sv */
// assertion checker for the host bus register bank ports
`timescale 1ns/10ps
module hbb_bank_props (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic host_strobe,
    input wire logic host_write,
    input wire logic [15:0] host_addr,
    input wire logic [3:0] host_be,
    input wire logic [31:0] host_wdata,
    input wire logic host_ack,
    input wire logic [31:0] host_rdata,
    input wire logic ee_rd_req,
    input wire logic [5:0] ee_rd_addr,
    input wire logic ee_rd_ack,
    input wire logic [5:0] bank_choice_field,
    input wire logic [11:0] rx_hiwm_bytes,
    input wire logic [4:0] burst_beats,
    input wire logic load_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    function automatic logic [4:0] beats_of(input logic [2:0] c);
        case (c)
            hbb_pkg::BURST_4: beats_of = hbb_pkg::BEATS_4;
            hbb_pkg::BURST_8: beats_of = hbb_pkg::BEATS_8;
            hbb_pkg::BURST_16: beats_of = hbb_pkg::BEATS_16;
            default: beats_of = hbb_pkg::BEATS_1;
        endcase
    endfunction

    sequence s_ee_step;
        ee_rd_req && ee_rd_ack && ee_rd_addr < 6'h03;
    endsequence
    sequence s_ee_last;
        ee_rd_req && ee_rd_ack && ee_rd_addr == 6'h03;
    endsequence
    sequence s_wr_ack(w, logic [3:0] lanes);
        host_ack && $past(host_write) && $past(host_addr[3:2]) == w && ($past(host_be) & lanes) != 4'h0
            && hbb_pkg::hbb_be_legal($past(host_be));
    endsequence

    ack_has_cause_a: assert property (host_ack |-> $past(host_strobe) && $past(load_done) && !$past(host_addr[4]))
        else $error("ack without a taken strobe");
    rdata_quiet_a: assert property (!host_ack || $past(host_write) |-> host_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    bank_write_a: assert property (s_wr_ack(2'h3, 4'h4) |-> bank_choice_field == $past(host_wdata[21:16]))
        else $error("bank selector not updated by its write");
    bank_hold_a: assert property (bank_choice_field != $past(bank_choice_field) |-> host_ack && $past(host_write))
        else $error("bank selector changed without a write");
    wmark_out_a: assert property (s_wr_ack(2'h1, 4'h2) ##0 bank_choice_field == hbb_pkg::BANK_BASE
        |-> rx_hiwm_bytes == ($past(host_wdata[12]) ? hbb_pkg::WM_2K_BYTES : hbb_pkg::WM_3K_BYTES))
        else $error("watermark size does not follow its bit");
    burst_out_a: assert property (s_wr_ack(2'h2, 4'h2) ##0 bank_choice_field == hbb_pkg::BANK_BASE
        |-> burst_beats == beats_of($past(host_wdata[14:12])))
        else $error("burst beats do not follow the burst code");
    ee_order_a: assert property (s_ee_step |=> ee_rd_req && ee_rd_addr == $past(ee_rd_addr) + 6'h01)
        else $error("eeprom words not fetched in order");
    ee_finish_a: assert property (s_ee_last |=> !ee_rd_req && load_done)
        else $error("load not finished after the last eeprom word");
    ee_hold_a: assert property (ee_rd_req && !ee_rd_ack |=> ee_rd_req && $stable(ee_rd_addr))
        else $error("eeprom request dropped or moved before its answer");
endmodule

/* File: hbb_ee_model.sv */
// eeprom word-read partner, answering promptly and slowly in turn
`timescale 1ns/10ps
module hbb_ee_model #(
    parameter logic [63:0] IMG = 64'h0
) (
    input wire logic clk_sys,
    input wire logic ee_rd_req,
    input wire logic [5:0] ee_rd_addr,
    output logic ee_rd_ack,
    output logic [15:0] ee_rd_data
);
    int wait_cnt = 0;
    logic slow = 1'b0;
    initial begin
        ee_rd_ack = 1'b0;
        ee_rd_data = 16'hA5A5;
    end
    always @(posedge clk_sys) begin
        ee_rd_ack <= 1'b0;
        // data inverts every cycle between answers, so a sample one cycle late sees the last word inverted
        ee_rd_data <= ~ee_rd_data;
        if (ee_rd_req === 1'b1 && ee_rd_ack !== 1'b1) begin
            if (wait_cnt > 0) begin
                wait_cnt <= wait_cnt - 1;
            end else begin
                ee_rd_ack <= 1'b1;
                ee_rd_data <= IMG[{ee_rd_addr[1:0], 4'h0} +: 16];
                wait_cnt <= slow ? 2 : 0;
                slow <= ~slow;
            end
        end
    end
endmodule

/* File: test_hbb_host_bus_bank.sv */
// self-checking bench for the host bus register bank
`timescale 1ns/10ps
module test_hbb_host_bus_bank;
    localparam logic [63:0] EE_IMG = 64'h0123_4567_89AB_05A7;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0, eeprom_present_pin = 1'b0, host_strobe = 1'b0, host_write = 1'b0;
    logic sync_xfer_active = 1'b0, async_xfer_active = 1'b0;
    logic [15:0] host_addr = 16'h0000;
    logic [3:0] host_be = 4'h0;
    logic [31:0] host_wdata = 32'h0;
    logic host_ack, ee_rd_req, ee_rd_ack, load_done;
    logic [31:0] host_rdata;
    logic [5:0] ee_rd_addr, bank_choice_field;
    logic [15:0] ee_rd_data, r0, r1, r2, lfsr = 16'h0059;
    logic [11:0] rx_hiwm_bytes;
    logic [4:0] burst_beats;
    logic [31:0] exp_q[$], msk_q[$];
    int bad_count = 0, cmp_count = 0;
    logic [2:0] codes [5] = '{hbb_pkg::BURST_SINGLE, hbb_pkg::BURST_4, hbb_pkg::BURST_8, hbb_pkg::BURST_16, 3'h1};
    logic [4:0] beats [5] = '{hbb_pkg::BEATS_1, hbb_pkg::BEATS_4, hbb_pkg::BEATS_8, hbb_pkg::BEATS_16, hbb_pkg::BEATS_1};

    always #2.5 clk_sys = ~clk_sys;

    hbb_host_bus_bank dut (.clk_sys(clk_sys), .arst_n(arst_n), .eeprom_present_pin(eeprom_present_pin),
        .host_strobe(host_strobe), .host_write(host_write), .host_addr(host_addr), .host_be(host_be),
        .host_wdata(host_wdata), .sync_xfer_active(sync_xfer_active), .async_xfer_active(async_xfer_active),
        .host_ack(host_ack), .host_rdata(host_rdata), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
        .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data), .bank_choice_field(bank_choice_field),
        .rx_hiwm_bytes(rx_hiwm_bytes), .burst_beats(burst_beats), .load_done(load_done));
    hbb_ee_model #(.IMG(EE_IMG)) u_ee (.clk_sys(clk_sys), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
        .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data));

    task automatic rnd(output logic [15:0] v);
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        v = lfsr;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobe stays high so calls in a row give back-to-back accesses
    task automatic bus(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd,
                       input logic acked, input logic [31:0] e, input logic [31:0] m);
        @(negedge clk_sys);
        host_strobe = 1'b1;
        host_write = w;
        host_addr = a;
        host_be = be;
        host_wdata = wd;
        if (acked) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd);
        bus(1'b1, a, be, wd, 1'b1, 32'h0, 32'hFFFF_FFFF);
    endtask
    task automatic rd(input logic [15:0] a, input logic [3:0] be, input logic [31:0] e);
        bus(1'b0, a, be, 32'h0, 1'b1, e, 32'hFFFF_FFFF);
    endtask
    task automatic miss(input logic [15:0] a);
        bus(1'b0, a, 4'hF, 32'h0, 1'b0, 32'h0, 32'h0);
    endtask
    task automatic idle(input int n);
        @(negedge clk_sys);
        host_strobe = 1'b0;
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic end_test(input string name);
        idle(3);
        check(32'(exp_q.size()), 32'h0);
        $display("test %s done", name);
    endtask
    task automatic do_reset(input logic pin);
        arst_n = 1'b0;
        eeprom_present_pin = pin;
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b1;
    endtask
    task automatic wait_load();
        for (int i = 0; i < 200 && load_done !== 1'b1; i++) @(negedge clk_sys);
        check(32'(load_done), 32'h1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // scoreboard: every answer takes the oldest note
    always @(posedge clk_sys) begin : mon
        logic [31:0] m;
        if (host_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("Error at %0t ns: got %h expected %h (no ack)", $time, host_rdata, 32'h0);
            end else begin
                m = msk_q.pop_front();
                check(host_rdata & m, exp_q.pop_front() & m);
            end
        end
    end

    initial begin
        #50000;
        bad_count++;
        $display("Error at %0t ns: got %h expected %h (timeout)", $time, 32'h0, 32'h1);
        wrap_up();
    end

    initial begin
        do_reset(1'b0);
        wait_load();
        check(32'(rx_hiwm_bytes), 32'(hbb_pkg::WM_3K_BYTES));
        check(32'(burst_beats), 32'(hbb_pkg::BEATS_1));
        rd(16'h0300, 4'hF, 32'h0000_0300);
        rd(16'h0304, 4'hF, 32'h0);
        rd(16'h0308, 4'hF, 32'h0);
        rd(16'h030C, 4'hF, 32'h0);
        miss(16'h0400);
        miss(16'h0320);
        miss(16'h0310);
        end_test("reset_values");
        for (int i = 0; i < 5; i++) begin
            wr(16'h0308, 4'h3, {17'h0, codes[i], 12'h0});
            rd(16'h0308, 4'h3, {17'h0, codes[i], 12'h0});
            idle(1);
            check(32'(burst_beats), 32'(beats[i]));
        end
        for (int i = 1; i >= 0; i--) begin
            wr(16'h0304, 4'h3, {19'h0, i[0], 12'h0});
            rd(16'h0304, 4'h3, {19'h0, i[0], 12'h0});
            idle(1);
            check(32'(rx_hiwm_bytes), 32'(i[0] ? hbb_pkg::WM_2K_BYTES : hbb_pkg::WM_3K_BYTES));
        end
        end_test("burst_watermark");
        rnd(r0);
        rnd(r1);
        rnd(r2);
        sync_xfer_active = 1'b1;
        @(negedge clk_sys);
        sync_xfer_active = 1'b0;
        async_xfer_active = 1'b1;
        rd(16'h0304, 4'hC, 32'h0);
        sync_xfer_active = 1'b1;
        idle(0);
        sync_xfer_active = 1'b0;
        async_xfer_active = 1'b0;
        rd(16'h0304, 4'hC, 32'h0400_0000);
        wr(16'h0300, 4'h5, {r1, r0});
        rd(16'h0300, 4'h3, 32'h0000_0300);
        rd(16'h0304, 4'hC, 32'hAC00_0000);
        wr(16'h0304, 4'hC, 32'h0);
        rd(16'h0304, 4'hC, 32'hAC00_0000);
        wr(16'h0304, 4'hC, 32'h0400_0000);
        rd(16'h0304, 4'hC, 32'hA800_0000);
        rd(16'h0300, 4'h6, 32'h0);
        rd(16'h0304, 4'hC, 32'hB000_0000);
        wr(16'h0304, 4'hC, 32'h8000_0000);
        bus(1'b0, 16'h0304, 4'hC, 32'h0, 1'b1, 32'h0, 32'h8400_0000);
        end_test("bus_errors");
        wr(16'h030C, 4'hF, 32'h0002_0000);
        rd(16'h030C, 4'hF, 32'h0002_0000);
        wr(16'h0300, 4'hF, {r1, r0});
        wr(16'h0304, 4'h3, {16'h0, r2});
        rd(16'h0300, 4'hF, {r1, r0});
        rd(16'h0304, 4'hF, {16'h0, r2});
        wr(16'h030C, 4'hC, 32'h0001_0000);
        rd(16'h0300, 4'hF, 32'h0);
        rd(16'h0308, 4'hF, 32'h0);
        rd(16'h030C, 4'hC, 32'h0001_0000);
        wr(16'h030C, 4'h4, 32'h003F_0000);
        idle(1);
        check(32'(bank_choice_field), 32'h3F);
        rd(16'h0300, 4'hF, 32'h0);
        wr(16'h030C, 4'h4, 32'h0);
        rd(16'h0300, 4'h3, 32'h0000_0300);
        wr(16'h0300, 4'h3, 32'h0000_0440);
        miss(16'h0300);
        rd(16'h0440, 4'h3, 32'h0000_0440);
        miss(16'h0460);
        end_test("bank_and_base");
        do_reset(1'b1);
        miss(16'h05A0);
        idle(0);
        wait_load();
        rd(16'h05A0, 4'h3, 32'h0000_05A0);
        miss(16'h0440);
        wr(16'h05AC, 4'hF, 32'h0002_0000);
        rd(16'h05A0, 4'hF, {EE_IMG[47:32], EE_IMG[31:16]});
        rd(16'h05A4, 4'h3, {16'h0, EE_IMG[63:48]});
        end_test("eeprom_load");
        wrap_up();
    end
endmodule

bind hbb_host_bus_bank hbb_bank_props u_props (.clk_sys(clk_sys), .arst_n(arst_n), .host_strobe(host_strobe),
    .host_write(host_write), .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
    .host_ack(host_ack), .host_rdata(host_rdata), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
    .ee_rd_ack(ee_rd_ack), .bank_choice_field(bank_choice_field), .rx_hiwm_bytes(rx_hiwm_bytes),
    .burst_beats(burst_beats), .load_done(load_done));
